// file: logic/servo_torque_limit_status.sv
// top of the torque limit and motion status block with register port
`timescale 1ns/1ps
`include "stl_map.svh"
module servo_torque_limit_status
    import stl_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire stl_bus_type        regBus,
    output logic [15:0]             rdData,
    input  wire logic signed [15:0] torqueCmdAnalogIn,
    input  wire logic signed [15:0] altCmdAnalogIn,
    input  wire logic signed [31:0] posErrCount,
    input  wire logic signed [15:0] motorSpeed,
    output logic signed [15:0]      torqueCmdOut,
    output logic                    inPositionFlag,
    output logic                    zeroSpeedFlag,
    output logic                    irq
);

    // setting registers
    logic [15:0]          mode_ff;
    logic [15:0]          gain_ff;
    logic [15:0]          invert_ff;
    logic [15:0]          limit_ff;
    logic [15:0]          window_ff;
    logic [15:0]          zspd_ff;

    // interrupt registers
    logic [`STL_IRQ_W-1:0] irqStat_ff;
    logic [`STL_IRQ_W-1:0] irqEn_ff;
    logic [`STL_IRQ_W-1:0] nxt_irqStat;
    logic [`STL_IRQ_W-1:0] events;
    logic                  irq_ff;

    // output and history registers
    logic signed [15:0]   torque_ff;
    logic                 inPos_ff;
    logic                 zspd_flag_ff;
    logic                 clamp_ff;
    logic [15:0]          rdData_ff;

    // datapath wires
    stl_cfg_type          cfg;
    logic signed [15:0]   cmdSel;
    logic signed [15:0]   torquePct;
    logic                 clampHit;
    logic [31:0]          errMag;
    logic [31:0]          spdMag;
    logic                 nxt_inPos;
    logic                 nxt_zspd;
    logic                 wrMode;
    logic                 wrGain;
    logic                 wrInvert;
    logic                 wrLimit;
    logic                 wrWindow;
    logic                 wrZspd;
    logic                 wrIrqClr;
    logic                 wrIrqEn;
    logic [15:0]          nxt_rdData;

    // write decode; each strobe qualified by address
    assign wrMode   = regBus.wr && (regBus.addr == `STL_ADDR_MODE);
    assign wrGain   = regBus.wr && (regBus.addr == `STL_ADDR_GAIN);
    assign wrInvert = regBus.wr && (regBus.addr == `STL_ADDR_INVERT);
    assign wrLimit  = regBus.wr && (regBus.addr == `STL_ADDR_LIMIT);
    assign wrWindow = regBus.wr && (regBus.addr == `STL_ADDR_WINDOW);
    assign wrZspd   = regBus.wr && (regBus.addr == `STL_ADDR_ZSPD);
    assign wrIrqClr = regBus.wr && (regBus.addr == `STL_ADDR_IRQ_CLR);
    assign wrIrqEn  = regBus.wr && (regBus.addr == `STL_ADDR_IRQ_EN);

    // control mode; out-of-range values are dropped, not truncated
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_ff <= `STL_RST_MODE;
        end else if (wrMode && regBus.wdata <= `STL_MODE_MAX) begin
            mode_ff <= regBus.wdata;
        end
    end

    // command gain; a zero gain would make the divide meaningless
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gain_ff <= `STL_RST_GAIN;
        end else if (wrGain && regBus.wdata >= `STL_GAIN_MIN
                     && regBus.wdata <= `STL_GAIN_MAX) begin
            gain_ff <= regBus.wdata;
        end
    end

    // polarity inversion setting, 0 or 1 only
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            invert_ff <= `STL_RST_INVERT;
        end else if (wrInvert && regBus.wdata <= `STL_INVERT_MAX) begin
            invert_ff <= regBus.wdata;
        end
    end

    // torque limit; the system maximum is tighter than the field range,
    // so both bounds are checked and a refused write leaves the old value
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            limit_ff <= `STL_RST_LIMIT;
        end else if (wrLimit && regBus.wdata <= `STL_LIMIT_RANGE
                     && regBus.wdata <= `STL_SYS_MAX_TRQ) begin
            limit_ff <= regBus.wdata;
        end
    end

    // in-position window in encoder counts
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            window_ff <= `STL_RST_WINDOW;
        end else if (wrWindow && regBus.wdata <= `STL_WINDOW_MAX) begin
            window_ff <= regBus.wdata;
        end
    end

    // zero-speed threshold in r/min
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            zspd_ff <= `STL_RST_ZSPD;
        end else if (wrZspd && regBus.wdata <= `STL_ZSPD_MAX) begin
            zspd_ff <= regBus.wdata;
        end
    end

    // settings bundle handed to the scaler
    assign cfg.mode   = mode_ff;
    assign cfg.gain   = gain_ff;
    assign cfg.invert = invert_ff;
    assign cfg.limit  = limit_ff;
    assign cfg.window = window_ff;
    assign cfg.zspd   = zspd_ff;

    // source select: torque mode uses the alternate analogue pin
    assign cmdSel = (mode_ff == `STL_MODE_TORQUE) ? altCmdAnalogIn
                                                  : torqueCmdAnalogIn;

    stl_torque_scale u_scale (
        .cmdMv     (cmdSel),
        .cfg       (cfg),
        .torquePct (torquePct),
        .clampHit  (clampHit)
    );

    // clamped torque registered every cycle so a new limit acts at once
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            torque_ff <= 16'sh0000;
            clamp_ff  <= 1'b0;
        end else begin
            torque_ff <= torquePct;
            clamp_ff  <= clampHit;
        end
    end

    // error magnitude; the counter is in encoder resolution units, so the
    // window means different angles for the two encoder kinds
    assign errMag    = stl_abs32(posErrCount);
    assign nxt_inPos = errMag <= {16'h0000, window_ff};

    // speed magnitude so CW and CCW share one threshold
    assign spdMag   = stl_abs32(32'(motorSpeed));
    assign nxt_zspd = spdMag < {16'h0000, zspd_ff};

    // status flags, recomputed every cycle with no hysteresis; a small
    // window can therefore chatter, which is left to the host to avoid
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            inPos_ff     <= 1'b0;
            zspd_flag_ff <= 1'b0;
        end else begin
            inPos_ff     <= nxt_inPos;
            zspd_flag_ff <= nxt_zspd;
        end
    end

    // rising edges of the flags and of the clamp are the interrupt events
    assign events[`STL_IRQ_INPOS] = nxt_inPos && !inPos_ff;
    assign events[`STL_IRQ_ZSPD]  = nxt_zspd && !zspd_flag_ff;
    assign events[`STL_IRQ_CLAMP] = clampHit && !clamp_ff;

    // sticky status; a new event beats a clear in the same cycle
    always_comb begin
        nxt_irqStat = irqStat_ff;
        if (wrIrqClr) begin
            nxt_irqStat = irqStat_ff & ~regBus.wdata[`STL_IRQ_W-1:0];
        end
        nxt_irqStat = nxt_irqStat | events;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irqStat_ff <= '0;
        end else begin
            irqStat_ff <= nxt_irqStat;
        end
    end

    // interrupt enable mask
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irqEn_ff <= '0;
        end else if (wrIrqEn) begin
            irqEn_ff <= regBus.wdata[`STL_IRQ_W-1:0];
        end
    end

    // level interrupt; built from next state so it tracks the status bits
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_irqStat & irqEn_ff);
        end
    end

    // read mux; unmapped and write-only addresses read as zero
    always_comb begin
        nxt_rdData = 16'h0000;
        case (regBus.addr)
            `STL_ADDR_MODE:     nxt_rdData = mode_ff;
            `STL_ADDR_GAIN:     nxt_rdData = gain_ff;
            `STL_ADDR_INVERT:   nxt_rdData = invert_ff;
            `STL_ADDR_LIMIT:    nxt_rdData = limit_ff;
            `STL_ADDR_WINDOW:   nxt_rdData = window_ff;
            `STL_ADDR_ZSPD:     nxt_rdData = zspd_ff;
            `STL_ADDR_IRQ_STAT: nxt_rdData = {13'h0000, irqStat_ff};
            `STL_ADDR_IRQ_EN:   nxt_rdData = {13'h0000, irqEn_ff};
            `STL_ADDR_STATUS:   nxt_rdData = {13'h0000, clamp_ff,
                                              zspd_flag_ff, inPos_ff};
            `STL_ADDR_TORQUE:   nxt_rdData = torque_ff;
            default:            nxt_rdData = 16'h0000;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdData_ff <= 16'h0000;
        end else if (regBus.rd) begin
            rdData_ff <= nxt_rdData;
        end else begin
            rdData_ff <= 16'h0000;
        end
    end

    // outputs straight from flip-flops
    assign rdData         = rdData_ff;
    assign torqueCmdOut   = torque_ff;
    assign inPositionFlag = inPos_ff;
    assign zeroSpeedFlag  = zspd_flag_ff;
    assign irq            = irq_ff;

endmodule

// file: logic/stl_map.svh
// register offsets, field limits, reset values and encoder counts
`ifndef STL_MAP_SVH
`define STL_MAP_SVH

`define STL_ADDR_MODE      8'h02
`define STL_ADDR_GAIN      8'h5c
`define STL_ADDR_INVERT    8'h5d
`define STL_ADDR_LIMIT     8'h5e
`define STL_ADDR_WINDOW    8'h60
`define STL_ADDR_ZSPD      8'h61
`define STL_ADDR_IRQ_STAT  8'h70
`define STL_ADDR_IRQ_CLR   8'h71
`define STL_ADDR_IRQ_EN    8'h72
`define STL_ADDR_STATUS    8'h73
`define STL_ADDR_TORQUE    8'h74

`define STL_RST_MODE       16'h0000
`define STL_RST_GAIN       16'h001e
`define STL_RST_INVERT     16'h0000
`define STL_RST_LIMIT      16'h012c
`define STL_RST_WINDOW     16'h000a
`define STL_RST_ZSPD       16'h0032

`define STL_GAIN_MIN       16'h000a
`define STL_GAIN_MAX       16'h0064
`define STL_INVERT_MAX     16'h0001
`define STL_LIMIT_RANGE    16'h01f4
`define STL_SYS_MAX_TRQ    16'h012c
`define STL_WINDOW_MAX     16'h7fff
`define STL_ZSPD_MAX       16'h2710
`define STL_MODE_MAX       16'h000f

`define STL_MODE_INV_OK    16'h0005
`define STL_MODE_TORQUE    16'h0002

`define STL_CNT_17BIT      32'h0002_0000
`define STL_CNT_2500P      32'h0000_2710

`define STL_IRQ_INPOS      0
`define STL_IRQ_ZSPD       1
`define STL_IRQ_CLAMP      2
`define STL_IRQ_W          3

`endif

// file: logic/stl_pkg.sv
// shared types and arithmetic for the torque limit and status block
package stl_pkg;

    // register-port request from software
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } stl_bus_type;

    // settings currently in effect
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] gain;
        logic [15:0] invert;
        logic [15:0] limit;
        logic [15:0] window;
        logic [15:0] zspd;
    } stl_cfg_type;

    // magnitude of a signed 32-bit quantity
    function automatic logic [31:0] stl_abs32(input logic signed [31:0] v);
        stl_abs32 = v[31] ? 32'(-v) : 32'(v);
    endfunction

endpackage

// file: logic/stl_torque_scale.sv
// command scaling, polarity and torque clamp (combinational)
`timescale 1ns/1ps
`include "stl_map.svh"
module stl_torque_scale
    import stl_pkg::*;
(
    input  wire logic signed [15:0] cmdMv,
    input  wire stl_cfg_type        cfg,
    output logic signed [15:0]      torquePct,
    output logic                    clampHit
);

    logic signed [16:0] gainS;
    logic signed [16:0] quot;
    logic signed [16:0] pol;
    logic signed [16:0] lim;
    logic               invOn;

    // percent of rated = mV / gain, since gain units are 100 mV per 100%
    assign gainS = {1'b0, cfg.gain};
    assign quot  = 17'(cmdMv) / gainS;
    // inversion honoured only in the one mode that allows it
    assign invOn = (cfg.mode == `STL_MODE_INV_OK)
                   && cfg.invert[0];
    // positive sign means CCW; inverted positive command yields CW
    assign pol   = invOn ? 17'(-quot) : quot;
    assign lim   = {1'b0, cfg.limit};

    // symmetric clamp, evaluated on the live limit every cycle
    always_comb begin
        clampHit  = 1'b0;
        torquePct = 16'(pol);
        if (pol > lim) begin
            torquePct = 16'(lim);
            clampHit  = 1'b1;
        end else if (pol < -lim) begin
            torquePct = 16'(-lim);
            clampHit  = 1'b1;
        end
    end

endmodule

// file: dv/stl_host_model.sv
// host controller and encoder model driving the command and feedback
`timescale 1ns/1ps
module stl_host_model (
    input  wire logic               ref_clk,
    input  wire logic               slow,
    input  wire logic signed [15:0] setCmd,
    input  wire logic signed [15:0] setAlt,
    input  wire logic signed [31:0] setErr,
    input  wire logic signed [15:0] setSpd,
    output logic signed [15:0]      cmdOut,
    output logic signed [15:0]      altOut,
    output logic signed [31:0]      errOut,
    output logic signed [15:0]      spdOut
);
    logic [79:0] stage_ff = '0;
    logic [79:0] out_ff = '0;
    // a slow host settles one cycle late; levels move only at edges
    always_ff @(posedge ref_clk) begin
        stage_ff <= {setCmd, setAlt, setErr, setSpd};
        out_ff <= slow ? stage_ff : {setCmd, setAlt, setErr, setSpd};
    end
    assign {cmdOut, altOut, errOut, spdOut} = out_ff;
endmodule

// file: dv/stl_properties.sv
// checker: clamp, status flags, settings shadow and read port
`timescale 1ns/1ps
module stl_properties
    import stl_pkg::*;
(
    input wire logic               ref_clk,
    input wire logic               srst,
    input wire stl_bus_type        regBus,
    input wire logic [15:0]        rdData,
    input wire logic signed [15:0] torqueCmdAnalogIn,
    input wire logic signed [15:0] altCmdAnalogIn,
    input wire logic signed [31:0] posErrCount,
    input wire logic signed [15:0] motorSpeed,
    input wire logic signed [15:0] torqueCmdOut,
    input wire logic               inPositionFlag,
    input wire logic               zeroSpeedFlag,
    input wire logic               irq
);
    logic [15:0] mode_ff, inv_ff, lim_ff, win_ff, zs_ff, wd;
    assign wd = regBus.wdata;
    function automatic longint mag(input longint v);
        return (v < 0) ? -v : v;
    endfunction
    // shadow of accepted settings; refused writes leave it unchanged
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_ff <= 16'h0000;
            inv_ff <= 16'h0000;
            lim_ff <= 16'h012c;
            win_ff <= 16'h000a;
            zs_ff <= 16'h0032;
        end else if (regBus.wr) begin
            case (regBus.addr)
                8'h02: if (wd <= 16'h000f) mode_ff <= wd;
                8'h5d: if (wd <= 16'h0001) inv_ff <= wd;
                8'h5e: if (wd <= 16'h012c) lim_ff <= wd;
                8'h60: if (wd <= 16'h7fff) win_ff <= wd;
                8'h61: if (wd <= 16'h2710) zs_ff <= wd;
                default: ;
            endcase
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence enableOff;
        regBus.wr && regBus.addr == 8'h72 && wd == 16'h0000;
    endsequence
    sequence posCmd;
        !$past(srst) && $past(mode_ff) != 16'h0002
            && $past(torqueCmdAnalogIn) > 0;
    endsequence
    torque_clamp_a: assert property (
        !$past(srst) |-> mag(torqueCmdOut) <= $past(lim_ff))
        else $error("torque magnitude above limit");
    inpos_level_a: assert property (
        !$past(srst) |-> inPositionFlag ==
            (mag($past(posErrCount)) <= $past(win_ff)))
        else $error("in-position flag wrong");
    zspd_level_a: assert property (
        !$past(srst) |-> zeroSpeedFlag ==
            (mag($past(motorSpeed)) < $past(zs_ff)))
        else $error("zero-speed flag wrong");
    read_limit_a: assert property (
        regBus.rd && regBus.addr == 8'h5e |=> rdData == $past(lim_ff))
        else $error("limit readback wrong");
    rd_idle_a: assert property (
        !$past(srst) && !$past(regBus.rd) |-> rdData == 16'h0000)
        else $error("read data outside read cycle");
    alt_input_a: assert property (
        !$past(srst) && $past(mode_ff) == 16'h0002
            && $past(altCmdAnalogIn) == 0 |-> torqueCmdOut == 0)
        else $error("torque mode ignored alternate input");
    cmd_sign_a: assert property (
        posCmd ##0 ($past(mode_ff) != 16'h0005 || $past(inv_ff) == 0)
            |-> torqueCmdOut >= 0)
        else $error("positive command gave negative torque");
    inv_sign_a: assert property (
        posCmd ##0 ($past(mode_ff) == 16'h0005 && $past(inv_ff) == 1)
            |-> torqueCmdOut <= 0)
        else $error("inversion not applied");
    irq_off_a: assert property (enableOff |-> ##2 !irq)
        else $error("interrupt high with all disabled");
endmodule
bind servo_torque_limit_status stl_properties u_props (
    .ref_clk(ref_clk), .srst(srst), .regBus(regBus), .rdData(rdData),
    .torqueCmdAnalogIn(torqueCmdAnalogIn), .altCmdAnalogIn(altCmdAnalogIn),
    .posErrCount(posErrCount), .motorSpeed(motorSpeed),
    .torqueCmdOut(torqueCmdOut), .inPositionFlag(inPositionFlag),
    .zeroSpeedFlag(zeroSpeedFlag), .irq(irq));

// file: dv/test_servo_torque_limit_status.sv
// self-checking bench for the torque limit and status block
`timescale 1ns/1ps
module test_servo_torque_limit_status
    import stl_pkg::*;
;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic slow = 1'b0;
    stl_bus_type regBus = '0;
    logic signed [15:0] setCmd = 0, setAlt = 0, setSpd = 0;
    logic signed [31:0] setErr = 0;
    logic signed [15:0] cmdIn, altIn, spdIn, torqueOut;
    logic signed [31:0] errIn;
    logic [15:0] rdData;
    logic inPos, zSpd, irq;
    int err_count = 0, n_compared = 0;
    int mode = 0, gain = 30, inv = 0, lim = 300, win = 10, zs = 50;
    int unsigned seed = 49;
    logic [7:0] adr[6] = '{8'h02, 8'h5c, 8'h5d, 8'h5e, 8'h60, 8'h61};
    logic [15:0] bad[6] = '{16'h0010, 16'h0065, 16'h0002, 16'h012d,
                            16'h8000, 16'h2711};
    // window 20 keeps the in-position flag from chattering
    logic [15:0] good[6] = '{16'h0000, 16'h0014, 16'h0000, 16'h0096,
                             16'h0014, 16'h003c};
    logic [15:0] mds[3] = '{16'h0000, 16'h0002, 16'h0005};
    always #2.5 ref_clk = ~ref_clk;
    stl_host_model host (.ref_clk(ref_clk), .slow(slow), .setCmd(setCmd),
        .setAlt(setAlt), .setErr(setErr), .setSpd(setSpd), .cmdOut(cmdIn),
        .altOut(altIn), .errOut(errIn), .spdOut(spdIn));
    servo_torque_limit_status uut (.ref_clk(ref_clk), .srst(srst),
        .regBus(regBus), .rdData(rdData), .torqueCmdAnalogIn(cmdIn),
        .altCmdAnalogIn(altIn), .posErrCount(errIn), .motorSpeed(spdIn),
        .torqueCmdOut(torqueOut), .inPositionFlag(inPos),
        .zeroSpeedFlag(zSpd), .irq(irq));
    function automatic int rnd(input int span);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed % (2 * span + 1)) - span;
    endfunction
    function automatic int mag(input int v);
        return (v < 0) ? -v : v;
    endfunction
    function automatic int regval(input logic [7:0] a);
        case (a)
            8'h02: return mode;
            8'h5c: return gain;
            8'h5d: return inv;
            8'h5e: return lim;
            8'h60: return win;
            8'h61: return zs;
            default: return 0;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe; the model keeps only in-range values
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regBus <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        regBus.wr <= 1'b0;
        @(posedge ref_clk);
        case (a)
            8'h02: if (d <= 15) mode = d;
            8'h5c: if (d >= 10 && d <= 100) gain = d;
            8'h5d: if (d <= 1) inv = d;
            8'h5e: if (d <= 300) lim = d;
            8'h60: if (d <= 32767) win = d;
            8'h61: if (d <= 10000) zs = d;
            default: ;
        endcase
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        regBus <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge ref_clk);
        regBus.rd <= 1'b0;
        #1 chk(rdData, e);
        @(posedge ref_clk);
    endtask
    // apply levels through the host, then compare all three results
    task automatic drive(input int c, input int al, input int e, input int s);
        int t;
        setCmd <= 16'(c);
        setAlt <= 16'(al);
        setErr <= e;
        setSpd <= 16'(s);
        slow <= seed[0];
        repeat (3) @(posedge ref_clk);
        t = ((mode == 2) ? al : c) / gain;
        if (mode == 5 && inv == 1) t = -t;
        t = (t > lim) ? lim : (t < -lim) ? -lim : t;
        #1 chk(torqueOut, t);
        chk(inPos, mag(e) <= win);
        chk(zSpd, mag(s) < zs);
        @(posedge ref_clk);
    endtask
    task automatic end_of_test();
        $display("compared=%0d errors=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (100000) @(posedge ref_clk);
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        // defaults, then a refused and an accepted value per setting
        foreach (adr[i]) begin
            rd(adr[i], regval(adr[i]));
            wr(adr[i], bad[i]);
            rd(adr[i], regval(adr[i]));
            wr(adr[i], good[i]);
            rd(adr[i], regval(adr[i]));
        end
        wr(8'h33, 16'h00ff);
        rd(8'h33, 16'h0000);
        rd(8'h71, 16'h0000);
        foreach (mds[m]) begin
            wr(8'h02, mds[m]);
            for (int v = 0; v < 2; v++) begin
                wr(8'h5d, 16'(v));
                repeat (6) drive(rnd(9000), rnd(9000), rnd(40), rnd(90));
            end
        end
        // limit boundaries in torque mode; 500 exceeds the system cap
        wr(8'h02, 16'h0002);
        wr(8'h5e, 16'h0000);
        drive(0, 9000, 0, 0);
        wr(8'h5e, 16'h012c);
        drive(9000, -9000, 0, 0);
        drive(9000, 0, 0, 0);
        wr(8'h5e, 16'h01f4);
        drive(0, 9000, 0, 0);
        wr(8'h02, 16'h0000);
        // events: raise, mask, clear, read-only status
        wr(8'h72, 16'h0007);
        drive(0, 0, 5000, 5000);
        wr(8'h71, 16'h0007);
        rd(8'h70, 16'h0000);
        #1 chk(irq, 0);
        drive(0, 0, 0, 5000);
        rd(8'h70, 16'h0001);
        #1 chk(irq, 1);
        wr(8'h72, 16'h0006);
        #1 chk(irq, 0);
        drive(0, 0, 0, 0);
        rd(8'h70, 16'h0003);
        #1 chk(irq, 1);
        wr(8'h71, 16'h0003);
        drive(9000, 0, 0, 0);
        wr(8'h70, 16'hffff);
        rd(8'h70, 16'h0004);
        // live status and clamped torque stand while the inputs hold
        rd(8'h73, 16'h0007);
        rd(8'h74, 16'(lim));
        wr(8'h72, 16'h0000);
        #1 chk(irq, 0);
        // second reset in mid-run restores the defaults
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        // every setting of the model goes back to its default
        mode = 0;
        gain = 30;
        inv = 0;
        lim = 300;
        win = 10;
        zs = 50;
        rd(8'h02, regval(8'h02));
        rd(8'h5d, regval(8'h5d));
        rd(8'h61, regval(8'h61));
        rd(8'h5c, regval(8'h5c));
        rd(8'h5e, regval(8'h5e));
        rd(8'h60, regval(8'h60));
        end_of_test();
    end
endmodule
